// file: nsr_pkg.sv
// Package of constants and types for the nv store/recall host controller
package nsr_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam int CLK_MHZ = 125;
  // Timing figures in ns, counts derived at the 125 MHz clock
  localparam int SETUP_NS = 24;
  localparam int STROBE_NS = 48;
  localparam int HOLD_NS = 16;
  localparam int GRACE_NS = 25;
  // Assumed recall times; both must stay inside the 8-bit wait counter
  localparam int RECALL_NS = 2000;
  localparam int POWERUP_NS = 1000;
  localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_CYC = (HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int GRACE_CYC = (GRACE_NS * CLK_MHZ + 999) / 1000;
  localparam int RECALL_CYC = (RECALL_NS * CLK_MHZ + 999) / 1000;
  localparam int POWERUP_CYC = (POWERUP_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 8;
  localparam int SEQ_LEN = 6;
  localparam logic [15:0] SEQ_A0 = 16'h4e38;
  localparam logic [15:0] SEQ_A1 = 16'hb1c7;
  localparam logic [15:0] SEQ_A2 = 16'h83e0;
  localparam logic [15:0] SEQ_A3 = 16'h7c1f;
  localparam logic [15:0] SEQ_A4 = 16'h703f;
  localparam logic [15:0] CMD_STORE = 16'h8fc0;
  localparam logic [15:0] CMD_RECALL = 16'h4c63;
  localparam logic [15:0] CMD_AS_OFF = 16'h8b45;
  localparam logic [15:0] CMD_AS_ON = 16'h4b46;
  typedef enum logic [2:0] {
    NSR_OP_READ, NSR_OP_WRITE, NSR_OP_STORE, NSR_OP_RECALL,
    NSR_OP_AS_OFF, NSR_OP_AS_ON, NSR_OP_HW_STORE
  } nsr_op_t;
endpackage

// file: nsr_cyc_if.sv
// Interface between sequencer and the bus-cycle engine
`timescale 1ns/1ps
interface nsr_cyc_if;
  import nsr_pkg::*;
  logic start;
  logic is_write;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [1:0] be_n;
  logic busy;
  logic done;
  logic [DATA_W-1:0] rdata;
  modport master (output start, is_write, addr, wdata, be_n,
                  input busy, done, rdata);
  modport engine (input start, is_write, addr, wdata, be_n,
                  output busy, done, rdata);
endinterface

// file: nsr_cycle.sv
// One asynchronous SRAM read or write cycle, chip-select controlled
`timescale 1ns/1ps
module nsr_cycle
  import nsr_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  nsr_cyc_if.engine cyc,
  output logic e_n,
  output logic w_n,
  output logic g_n,
  output logic [1:0] be_n,
  output logic [ADDR_W-1:0] addr,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe_n,
  input wire logic [DATA_W-1:0] dq_in
);
  typedef enum logic [1:0] {C_IDLE, C_SETUP, C_STROBE, C_HOLD} nsr_cst_t;
  nsr_cst_t st;
  logic [CNT_W-1:0] cnt;
  logic wr;
  wire cnt_done = (cnt == '0);
  assign cyc.busy = (st != C_IDLE);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st <= C_IDLE;
      cnt <= '0;
      wr <= 1'b0;
      e_n <= 1'b1;
      w_n <= 1'b1;
      g_n <= 1'b1;
      be_n <= 2'b11;
      addr <= '0;
      dq_out <= '0;
      dq_oe_n <= 1'b1;
      cyc.done <= 1'b0;
      cyc.rdata <= '0;
    end else begin
      cyc.done <= 1'b0;
      if (!cnt_done) cnt <= cnt - 1'b1;
      case (st)
        C_IDLE: if (cyc.start) begin
          // Address and strobes settle before chip select falls
          addr <= cyc.addr;
          be_n <= cyc.be_n;
          wr <= cyc.is_write;
          w_n <= !cyc.is_write;
          g_n <= cyc.is_write;
          dq_out <= cyc.wdata;
          dq_oe_n <= !cyc.is_write;
          cnt <= CNT_W'(SETUP_CYC - 1);
          st <= C_SETUP;
        end
        // One clean falling edge of chip select per cycle
        C_SETUP: if (cnt_done) begin
          e_n <= 1'b0;
          cnt <= CNT_W'(STROBE_CYC - 1);
          st <= C_STROBE;
        end
        C_STROBE: if (cnt_done) begin
          e_n <= 1'b1;
          if (!wr) cyc.rdata <= dq_in;
          cnt <= CNT_W'(HOLD_CYC - 1);
          st <= C_HOLD;
        end
        C_HOLD: if (cnt_done) begin
          w_n <= 1'b1;
          g_n <= 1'b1;
          dq_oe_n <= 1'b1;
          cyc.done <= 1'b1;
          st <= C_IDLE;
        end
        default: st <= C_IDLE;
      endcase
    end
  end
endmodule

// file: nsr_host.sv
// Host controller issuing SRAM cycles and nonvolatile command sequences
// Functional notes
// - Store sequence: six ordered reads ending at 0x8FC0.
// - Host sequences use only reads with output drive and both bytes enabled.
// - Recall sequence: same five reads then 0x4C63.
// - Host gives each sequence read one clean falling edge.
// - Autostore disable: five common reads then 0x8B45.
// - Autostore enable: five common reads then 0x4B46.
// - Changed autostore setting persists only after a later store.
// - Host keeps write strobe high through all six sequence reads.
`timescale 1ns/1ps
module nsr_host
  import nsr_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic REQ_VALID,
  input wire nsr_pkg::nsr_op_t REQ_OP,
  input wire logic [nsr_pkg::ADDR_W-1:0] REQ_ADDR,
  input wire logic [nsr_pkg::DATA_W-1:0] REQ_WDATA,
  input wire logic [1:0] REQ_BE_N,
  output logic REQ_READY,
  output logic RSP_VALID,
  output logic [nsr_pkg::DATA_W-1:0] RSP_RDATA,
  output logic DEV_BUSY,
  output logic E_N,
  output logic W_N,
  output logic G_N,
  output logic HI_BYTE_N,
  output logic LO_BYTE_N,
  output logic [nsr_pkg::ADDR_W-1:0] A,
  output logic [nsr_pkg::DATA_W-1:0] DQ_OUT,
  output logic DQ_OE_N,
  input wire logic [nsr_pkg::DATA_W-1:0] DQ_IN,
  output logic STORE_REQ_BUSY_N_OUT,
  output logic STORE_REQ_BUSY_N_OE_N,
  input wire logic STORE_REQ_BUSY_N_IN
);
  import nsr_pkg::*;
  typedef enum logic [2:0] {
    S_IDLE, S_CYC, S_WAIT, S_HW_PULL, S_HW_WAIT
  } nsr_st_t;

  nsr_cyc_if cyc ();
  nsr_st_t st;
  nsr_op_t op;
  logic [2:0] step;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [1:0] be_n;
  logic start;
  logic [CNT_W-1:0] cnt;
  logic [1:0] be_pair;
  logic busy_q;

  // Only the low 16 bits carry the code; upper bits held zero
  wire logic [15:0] final_code =
    (op == NSR_OP_STORE)  ? CMD_STORE :
    (op == NSR_OP_RECALL) ? CMD_RECALL :
    (op == NSR_OP_AS_OFF) ? CMD_AS_OFF : CMD_AS_ON;
  // Address of the following step; every sequence opens at step 0
  wire logic [2:0] next_step = step + 3'd1;
  wire logic [15:0] next_code =
    (next_step == 3'd1) ? SEQ_A1 :
    (next_step == 3'd2) ? SEQ_A2 :
    (next_step == 3'd3) ? SEQ_A3 :
    (next_step == 3'd4) ? SEQ_A4 : final_code;
  wire logic is_seq = (op == NSR_OP_STORE) || (op == NSR_OP_RECALL) ||
                      (op == NSR_OP_AS_OFF) || (op == NSR_OP_AS_ON);
  wire logic last_step = (step == 3'(SEQ_LEN - 1));
  // Device busy pin low means a store is running
  wire logic dev_busy = !STORE_REQ_BUSY_N_IN;
  // A recall leaves the chip deaf while the busy pin stays high, so
  // the host can only count out the recall time
  wire logic [CNT_W-1:0] wait_len =
    (op == NSR_OP_RECALL) ? CNT_W'(RECALL_CYC) : CNT_W'(GRACE_CYC);
  // New orders only once the pin is high and every wait has run out;
  // the same counter covers the power-up recall after reset
  wire logic can_take = !dev_busy && (cnt == '0);
  wire logic req_rw = (REQ_OP == NSR_OP_READ) || (REQ_OP == NSR_OP_WRITE);
  // Sequence addresses keep the two upper address bits at zero
  wire logic [ADDR_W-1:0] seq_first = {{(ADDR_W-16){1'b0}}, SEQ_A0};
  wire logic [ADDR_W-1:0] seq_next = {{(ADDR_W-16){1'b0}}, next_code};

  assign cyc.start = start;
  assign cyc.is_write = (op == NSR_OP_WRITE);
  assign cyc.addr = addr;
  assign cyc.wdata = wdata;
  assign cyc.be_n = be_n;

  nsr_cycle u_cycle (
    .clk(CLK),
    .nrst(NRST),
    .cyc(cyc),
    .e_n(E_N),
    .w_n(W_N),
    .g_n(G_N),
    .be_n(be_pair),
    .addr(A),
    .dq_out(DQ_OUT),
    .dq_oe_n(DQ_OE_N),
    .dq_in(DQ_IN)
  );
  // Byte lanes travel as a pair and split only at the pins
  assign HI_BYTE_N = be_pair[1];
  assign LO_BYTE_N = be_pair[0];

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      st <= S_IDLE;
      op <= NSR_OP_READ;
      step <= '0;
      addr <= '0;
      wdata <= '0;
      be_n <= 2'b11;
      start <= 1'b0;
      // Chip recalls on power-up and is deaf until that ends; the wait
      // is loaded here so no order reaches it early
      cnt <= CNT_W'(POWERUP_CYC);
      busy_q <= 1'b1;
      REQ_READY <= 1'b0;
      RSP_VALID <= 1'b0;
      RSP_RDATA <= '0;
      DEV_BUSY <= 1'b1;
      STORE_REQ_BUSY_N_OUT <= 1'b1;
      STORE_REQ_BUSY_N_OE_N <= 1'b1;
    end else begin
      start <= 1'b0;
      RSP_VALID <= 1'b0;
      busy_q <= dev_busy;
      DEV_BUSY <= dev_busy;
      if (cnt != '0) cnt <= cnt - 1'b1;
      case (st)
        S_IDLE: begin
          // No cycle while device busy: writes would be refused
          // Ready drops a cycle after each offer so one valid is taken once
          REQ_READY <= can_take && !REQ_READY;
          if (REQ_READY && REQ_VALID) begin
            REQ_READY <= 1'b0;
            op <= REQ_OP;
            step <= '0;
            wdata <= REQ_WDATA;
            if (REQ_OP == NSR_OP_HW_STORE) begin
              // Pull the pin low, then hold it over the grace time
              STORE_REQ_BUSY_N_OUT <= 1'b0;
              STORE_REQ_BUSY_N_OE_N <= 1'b0;
              cnt <= CNT_W'(GRACE_CYC);
              st <= S_HW_PULL;
            end else begin
              if (req_rw) begin
                addr <= REQ_ADDR;
                be_n <= REQ_BE_N;
              end else begin
                // Sequence reads: both bytes, output drive
                // An autostore change lasts only once a store follows;
                // the caller orders that store
                addr <= seq_first;
                be_n <= 2'b00;
              end
              start <= 1'b1;
              st <= S_CYC;
            end
          end
        end
        S_CYC: if (cyc.done) begin
          if (is_seq && !last_step) begin
            // Strict order, back to back, write strobe high
            step <= step + 3'd1;
            addr <= seq_next;
            start <= 1'b1;
          end else begin
            RSP_VALID <= 1'b1;
            RSP_RDATA <= cyc.rdata;
            // Store/recall: wait for busy to rise again
            st <= S_WAIT;
            cnt <= wait_len;
          end
        end
        S_HW_PULL: if (cnt == '0) begin
          // Release; device keeps it low if a store runs
          STORE_REQ_BUSY_N_OUT <= 1'b1;
          STORE_REQ_BUSY_N_OE_N <= 1'b1;
          cnt <= CNT_W'(GRACE_CYC);
          st <= S_HW_WAIT;
        end
        // An ignored request never pulls the pin; the grace count alone
        // then decides when the answer goes out
        S_HW_WAIT: if (cnt == '0 && !busy_q) begin
          RSP_VALID <= 1'b1;
          st <= S_IDLE;
        end
        // Busy is seen one cycle late, so the count covers that gap
        // before the pin level is trusted
        S_WAIT: if (cnt == '0 && !busy_q) begin
          st <= S_IDLE;
        end
        default: st <= S_IDLE;
      endcase
    end
  end
endmodule

// file: nsr_host_checker.sv
// Port-level assertions for the nv store/recall host controller
`timescale 1ns/1ps
module nsr_host_checker(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic E_N,
  input wire logic W_N,
  input wire logic G_N,
  input wire logic [nsr_pkg::ADDR_W-1:0] A,
  input wire logic DEV_BUSY,
  input wire logic STORE_REQ_BUSY_N_OUT,
  input wire logic STORE_REQ_BUSY_N_OE_N,
  input wire logic STORE_REQ_BUSY_N_IN
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  rw_excl_a: assert property (!E_N |-> W_N || G_N)
    else $error("write with output drive");
  strobe_len_a: assert property ($fell(E_N) |-> (!E_N)[*6] ##1 E_N)
    else $error("chip select width");
  addr_hold_a: assert property (!E_N |-> $stable(A))
    else $error("address moved");
  req_low_a: assert property (!STORE_REQ_BUSY_N_OE_N |->
    !STORE_REQ_BUSY_N_OUT) else $error("request pin driven high");
  req_len_a: assert property ($fell(STORE_REQ_BUSY_N_OE_N) |->
    (!STORE_REQ_BUSY_N_OE_N)[*5] ##1 STORE_REQ_BUSY_N_OE_N)
    else $error("request pulse width");
  req_quiet_a: assert property (!STORE_REQ_BUSY_N_OE_N |-> E_N)
    else $error("access during request");
  busy_io_a: assert property (DEV_BUSY |-> E_N)
    else $error("access while busy");
  busy_seen_a: assert property (!STORE_REQ_BUSY_N_IN |=> DEV_BUSY)
    else $error("busy flag missed");
endmodule

bind nsr_host nsr_host_checker u_chk(.CLK(CLK), .NRST(NRST), .E_N(E_N),
  .W_N(W_N), .G_N(G_N), .A(A), .DEV_BUSY(DEV_BUSY),
  .STORE_REQ_BUSY_N_OUT(STORE_REQ_BUSY_N_OUT),
  .STORE_REQ_BUSY_N_OE_N(STORE_REQ_BUSY_N_OE_N),
  .STORE_REQ_BUSY_N_IN(STORE_REQ_BUSY_N_IN));

// file: nsr_dev_model.sv
// Behavioural model of the shadowed SRAM on the far side
`timescale 1ns/1ps
module nsr_dev_model
  import nsr_pkg::*;
(
  input wire logic clk,
  input wire logic e_n,
  input wire logic w_n,
  input wire logic g_n,
  input wire logic hb_n,
  input wire logic lb_n,
  input wire logic [ADDR_W-1:0] a,
  input wire logic [DATA_W-1:0] dq_out,
  input wire logic dq_oe_n,
  output logic [DATA_W-1:0] dq_in,
  input wire logic pin,
  output logic pin_low
);
  localparam int STORE_LEN = 20;
  localparam int RECALL_LEN = 100;
  logic [15:0] mem [16];
  logic [15:0] nv [16];
  logic [15:0] seq [5] = '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4};
  logic [15:0] pat = 16'h0;
  logic e_q = 1'b1;
  logic dirty = 1'b0;
  logic as_en = 1'b1;
  logic as_nv = 1'b1;
  int step = 0;
  int busy = 0;
  // Power-up recall keeps the array shut for a while
  int rc_busy = RECALL_LEN;
  int low_cnt = 0;
  int n_store = 0;
  wire logic idle = busy == 0 && rc_busy == 0;
  wire logic [15:0] a16 = a[15:0];
  wire logic rd_end = e_n && !e_q && !g_n && w_n;
  wire logic wr_end = e_n && !e_q && !w_n && !dq_oe_n;
  wire logic last = rd_end && step == 5;
  wire logic hw_go = low_cnt == GRACE_CYC - 1 && dirty;
  wire logic sw_go = last && a16 == CMD_STORE;
  // Undriven bus shows a moving pattern so stale data cannot pass;
  // reads are not served while a store or recall keeps the array busy
  assign dq_in = (!g_n && !(e_n && e_q) && idle) ? mem[a[3:0]] : pat;
  assign pin_low = busy != 0;
  always @(posedge clk) begin
    e_q <= e_n;
    pat <= pat + 16'h1;
    low_cnt <= (pin === 1'b0 && busy == 0) ? low_cnt + 1 : 0;
    if (busy != 0)
      busy <= busy - 1;
    if (rc_busy != 0)
      rc_busy <= rc_busy - 1;
    if (wr_end && idle && pin !== 1'b0) begin
      if (!lb_n)
        mem[a[3:0]][7:0] <= dq_out[7:0];
      if (!hb_n)
        mem[a[3:0]][15:8] <= dq_out[15:8];
      dirty <= 1'b1;
    end
    if (rd_end)
      step <= (step < 5 && a16 == seq[step]) ? step + 1 :
              32'(a16 == SEQ_A0);
    if (last && a16 == CMD_RECALL) begin
      mem <= nv;
      dirty <= 1'b0;
      rc_busy <= RECALL_LEN;
    end
    if (last && a16 == CMD_AS_OFF)
      as_en <= 1'b0;
    if (last && a16 == CMD_AS_ON)
      as_en <= 1'b1;
    if (hw_go || sw_go) begin
      nv <= mem;
      as_nv <= as_en;
      dirty <= 1'b0;
      busy <= STORE_LEN;
      n_store <= n_store + 1;
    end
  end
endmodule

// file: nsr_host_tb.sv
// Self-checking testbench for the nv store/recall host controller
`timescale 1ns/1ps
module nsr_host_tb;
  import nsr_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic req_valid = 1'b0;
  nsr_op_t req_op = NSR_OP_READ;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [DATA_W-1:0] req_wdata = '0;
  logic [1:0] req_be_n = 2'b00;
  logic req_ready, rsp_valid, dev_busy, e_n, w_n, g_n, hb_n, lb_n;
  logic [ADDR_W-1:0] a;
  logic [DATA_W-1:0] rsp_rdata, dq_out, dq_in;
  logic dq_oe_n, pin_out, pin_oe_n, dev_low;
  // Weak pull-up on the request/busy wire
  wire logic pin = !((!pin_oe_n && !pin_out) || dev_low);
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  nsr_host uut(.CLK(clk), .NRST(nrst), .REQ_VALID(req_valid),
    .REQ_OP(req_op), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata),
    .REQ_BE_N(req_be_n), .REQ_READY(req_ready), .RSP_VALID(rsp_valid),
    .RSP_RDATA(rsp_rdata), .DEV_BUSY(dev_busy), .E_N(e_n), .W_N(w_n),
    .G_N(g_n), .HI_BYTE_N(hb_n), .LO_BYTE_N(lb_n), .A(a),
    .DQ_OUT(dq_out), .DQ_OE_N(dq_oe_n), .DQ_IN(dq_in),
    .STORE_REQ_BUSY_N_OUT(pin_out), .STORE_REQ_BUSY_N_OE_N(pin_oe_n),
    .STORE_REQ_BUSY_N_IN(pin));
  nsr_dev_model dev(.clk(clk), .e_n(e_n), .w_n(w_n), .g_n(g_n),
    .hb_n(hb_n), .lb_n(lb_n), .a(a), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .dq_in(dq_in), .pin(pin), .pin_low(dev_low));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic do_op(input nsr_op_t op, input logic [17:0] ad,
                       input logic [15:0] d, input logic [1:0] be);
    @(negedge clk);
    req_op = op;
    req_addr = ad;
    req_wdata = d;
    req_be_n = be;
    req_valid = 1'b1;
    do @(posedge clk); while (req_ready !== 1'b1);
    @(negedge clk);
    req_valid = 1'b0;
    do @(posedge clk); while (rsp_valid !== 1'b1);
  endtask
  task automatic t_as();
    chk(16'(dev.as_en), 16'h1);
    do_op(NSR_OP_AS_OFF, 18'h0, 16'h0, 2'b00);
    chk(16'(dev.as_en), 16'h0);
    do_op(NSR_OP_STORE, 18'h0, 16'h0, 2'b00);
    chk(16'(dev.as_nv), 16'h0);
    do_op(NSR_OP_AS_ON, 18'h0, 16'h0, 2'b00);
    chk(16'(dev.as_en), 16'h1);
    $display("test autostore done");
  endtask
  task automatic t_store();
    do_op(NSR_OP_WRITE, 18'h1, 16'h1234, 2'b00);
    do_op(NSR_OP_STORE, 18'h0, 16'h0, 2'b00);
    chk(16'(dev_busy), 16'h1);
    chk(dev.nv[1], 16'h1234);
    do_op(NSR_OP_STORE, 18'h0, 16'h0, 2'b00);
    chk(16'(dev.n_store), 16'h3);
    $display("test store done");
  endtask
  task automatic t_rw();
    do_op(NSR_OP_WRITE, 18'h30005, 16'h5a5a, 2'b00);
    do_op(NSR_OP_WRITE, 18'h00005, 16'h00c3, 2'b10);
    do_op(NSR_OP_READ, 18'h00005, 16'h0, 2'b00);
    chk(rsp_rdata, 16'h5ac3);
    $display("test read write done");
  endtask
  task automatic t_recall();
    do_op(NSR_OP_WRITE, 18'h1, 16'hbeef, 2'b00);
    do_op(NSR_OP_RECALL, 18'h0, 16'h0, 2'b00);
    do_op(NSR_OP_READ, 18'h1, 16'h0, 2'b00);
    chk(rsp_rdata, 16'h1234);
    chk(dev.nv[1], 16'h1234);
    $display("test recall done");
  endtask
  task automatic t_hw();
    do_op(NSR_OP_WRITE, 18'h2, 16'h00c3, 2'b00);
    do_op(NSR_OP_HW_STORE, 18'h0, 16'h0, 2'b00);
    chk(dev.nv[2], 16'h00c3);
    do_op(NSR_OP_HW_STORE, 18'h0, 16'h0, 2'b00);
    chk(16'(dev.n_store), 16'h4);
    $display("test hardware store done");
  endtask
  task automatic t_abort();
    logic [15:0] s [7] = '{16'h4e38, 16'hb1c7, 16'h0001, 16'h83e0,
                           16'h7c1f, 16'h703f, 16'h8fc0};
    foreach (s[i]) begin
      do_op(NSR_OP_READ, {2'b00, s[i]}, 16'h0, 2'b00);
      if (s[i] == 16'h0001)
        chk(rsp_rdata, 16'h1234);
    end
    chk(16'(dev.n_store), 16'h4);
    $display("test broken sequence done");
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Whole run needs under two thousand cycles; this ceiling only cuts hangs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    t_as();
    t_store();
    t_rw();
    t_recall();
    t_hw();
    t_abort();
    tally_and_finish();
  end
endmodule
